// File: rtl/parallel_host_port_interface.sv
/*
  parallel host port: lets an external host reach the internal memory
  space through control, address and data accesses, in multiplexed
  half-word, multiplexed fullword or non-multiplexed fullword mode.
  also holds the request fifo that sits between host and memory.
  assumes host pins are synchronous to mclk and that configuration
  and page bytes come from processor-owned registers outside.
*/
// Behaviour
// - chip select and strobes form one strobe
// - address/control at strobe start, data at end
// - ready only drops while chip selected
// - type pins pick control, data, address target
// - non-multiplexed mode: control and plain data only
// - half-word mode: two 16-bit transfers per word
// - upper data lines driven on reads unless gpio
// - multiplexed modes may force page upper bits
// - multiplexed data accesses start at loaded address
// - ready held off until read data returns or write is queued
// - processor can raise host interrupt output
// - host control bit interrupts the processor
// - fullword mode: 32 lines, one cycle each
// - non-multiplexed: sram-like random 64k page access
// - non-multiplexed page bits only from processor
// - non-multiplexed enable makes shared pins inputs
// - boot sets non-multiplexed before memory drives
// - config bit 2 selects non-multiplexed mode
// - config bit 3 selects half or fullword
// - config bit 1 enables page mode
`timescale 1ns/1ps

// -------------------------------------------------------------
// request fifo, flip-flop storage
// -------------------------------------------------------------
module host_req_fifo #(
  parameter int WIDTH = 69,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset_n,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];  // storage words
  logic [AW-1:0]    wr_ptr;          // next write slot
  logic [AW-1:0]    rd_ptr;          // next read slot
  logic [AW:0]      count;           // words held
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // full at exactly depth words; the count is one bit wider than the pointers
  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = store[rd_ptr];

  // pointers and fill count
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge mclk) begin
    if (push) store[wr_ptr] <= in_data;
  end
endmodule

// -------------------------------------------------------------
// host port top
// -------------------------------------------------------------
module parallel_host_port_interface #(
  parameter int FIFO_DEPTH = host_port_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        reset_n,
  // host strobes and access controls
  input  wire logic        host_chip_select_n,
  input  wire logic [1:0]  host_data_strobes_n,
  input  wire logic [1:0]  host_access_type,
  input  wire logic        host_read,
  input  wire logic [3:0]  host_byte_enables_n,
  input  wire logic        halfword_select,
  input  wire logic [15:0] host_address_inputs,
  // host data bus, split into three signals
  input  wire logic [31:0] host_data_bus_in,
  output logic      [31:0] host_data_bus_out,
  output logic      [31:0] host_data_bus_oe,
  // host handshake and interrupt
  output logic             host_ready_out,
  output logic             host_interrupt_out_n,
  // processor-side configuration
  input  wire logic [4:0]  host_port_config,
  input  wire logic [7:0]  page_addr_top_byte,
  input  wire logic [7:0]  page_addr_upper_mid_byte,
  input  wire logic        upper_lines_gpio,
  input  wire logic        host_int_set,
  output logic             cpu_interrupt,
  output logic             memory_upper_data_pins_input,
  // internal memory request and response
  output logic             mem_valid,
  input  wire logic        mem_ready,
  output host_port_pkg::mem_req_type mem_req,
  input  wire logic        mem_rvalid,
  input  wire logic [31:0] mem_rdata
);
  typedef enum {st_idle, st_rd_push, st_rd_wait, st_wr_push} state_type;

  state_type   state;            // access sequencer
  state_type   next_state;
  logic        strobe_s1;        // synchroniser first stage
  logic        strobe_s2;        // synchronised strobe
  logic        strobe_s3;        // delayed, for edges
  logic [1:0]  acc_type;         // type taken at strobe start
  logic        acc_read;         // direction taken at strobe start
  logic        acc_half;         // half select taken at strobe start
  logic [3:0]  acc_be;           // enables taken at strobe start
  logic [15:0] acc_ha;           // address pins taken at start
  logic [31:0] address_reg;      // host address register
  logic [31:0] control_reg;      // host control register
  logic [15:0] low_half;         // first half of a half-word write
  logic [31:0] read_word;        // last word read from memory
  logic [31:0] out_word;         // word presented on reads
  logic [31:0] wr_word_q;        // write word held until pushed

  // ---------------------------------------------------------
  // decoded configuration
  // ---------------------------------------------------------
  // port enable
  wire cfg_en    = host_port_config[host_port_pkg::CFG_ENABLE];
  wire cfg_nonmux_enable  = host_port_config[host_port_pkg::CFG_NONMUX];
  wire cfg_half  = ~cfg_nonmux_enable & ~host_port_config[host_port_pkg::CFG_FULL];
  wire cfg_page  = ~cfg_nonmux_enable & host_port_config[host_port_pkg::CFG_PAGE];
  wire cfg_byte  = host_port_config[host_port_pkg::CFG_BYTEAD];
  wire [15:0] page_hi = {page_addr_top_byte, page_addr_upper_mid_byte};

  assign memory_upper_data_pins_input = cfg_nonmux_enable;

  // ---------------------------------------------------------
  // strobe combination and edges
  // ---------------------------------------------------------
  // combined strobe
  wire strobe_raw = ~host_chip_select_n & (host_data_strobes_n[0] ^ host_data_strobes_n[1]);
  wire strobe_start = strobe_s2 & ~strobe_s3 & cfg_en;
  wire strobe_end   = ~strobe_s2 & strobe_s3 & cfg_en;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      strobe_s1 <= 1'b0;
      strobe_s2 <= 1'b0;
      strobe_s3 <= 1'b0;
    end else begin
      strobe_s1 <= strobe_raw;
      strobe_s2 <= strobe_s1;
      strobe_s3 <= strobe_s2;
    end
  end

  // ---------------------------------------------------------
  // address forming
  // ---------------------------------------------------------
  // word addresses scale to bytes; page bits override the top half
  function automatic logic [31:0] form_addr(input logic [31:0] a);
    logic [31:0] b;
    b = cfg_byte ? a : {a[29:0], 2'b00};
    if (cfg_page || cfg_nonmux_enable) b = {page_hi, b[15:0]};
    return b;
  endfunction

  function automatic logic type_allowed(input logic [1:0] t);
    return ~cfg_nonmux_enable | (t == host_port_pkg::ACC_CONTROL) | (t == host_port_pkg::ACC_DATA);
  endfunction
  // data window types; live pins at strobe start, captured type after
  function automatic logic data_type(input logic [1:0] t);
    return type_allowed(t) & t[0];
  endfunction
  wire type_ok  = type_allowed(acc_type);
  wire is_data  = data_type(acc_type);
  wire is_inc   = is_data & (acc_type == host_port_pkg::ACC_DATA_INC);
  wire word_done = ~cfg_half | acc_half;
  wire [31:0] data_addr = cfg_nonmux_enable ? form_addr({16'h0000, acc_ha})
                                   : form_addr(address_reg);
  wire [31:0] addr_step = cfg_byte ? host_port_pkg::STEP_BYTE : host_port_pkg::STEP_WORD;
  wire [31:0] wr_word   = cfg_half ? {host_data_bus_in[15:0], low_half} : host_data_bus_in;

  // ---------------------------------------------------------
  // request fifo toward memory
  // ---------------------------------------------------------
  host_port_pkg::mem_req_type fifo_in;
  logic                       fifo_in_ready;
  wire fifo_push = (state == st_rd_push) | (state == st_wr_push);
  assign fifo_in.write = (state == st_wr_push);
  assign fifo_in.be    = acc_be;
  assign fifo_in.addr  = data_addr;
  assign fifo_in.data  = wr_word_q;

  host_req_fifo #(
    .WIDTH ($bits(host_port_pkg::mem_req_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .reset_n   (reset_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (mem_valid),
    .out_ready (mem_ready),
    .out_data  (mem_req)
  );

  // ---------------------------------------------------------
  // access sequencer
  // ---------------------------------------------------------
  // read starts at strobe start; write waits for strobe end
  always_comb begin
    next_state = state;
    case (state)
      st_idle: begin
        // captured type is still stale at the start edge, so decode the pins
        if (strobe_start && host_read && data_type(host_access_type) &&
            !(cfg_half && halfword_select))
          next_state = st_rd_push;
        else if (strobe_end && !acc_read && is_data && word_done)
          next_state = st_wr_push;
      end
      st_rd_push: begin
        if (fifo_in_ready) next_state = st_rd_wait;
      end
      st_rd_wait: begin
        if (mem_rvalid) next_state = st_idle;
      end
      st_wr_push: begin
        if (fifo_in_ready) next_state = st_idle;
      end
      default: next_state = st_idle;
    endcase
  end

  // state and access capture
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state    <= st_idle;
      acc_type <= host_port_pkg::ACC_CONTROL;
      acc_read <= 1'b0;
      acc_half <= 1'b0;
      acc_be   <= 4'h0;
      acc_ha   <= 16'h0000;
    end else begin
      state <= next_state;
      if (strobe_start) begin
        acc_type <= host_access_type;
        acc_read <= host_read;
        acc_half <= halfword_select;
        acc_be   <= ~host_byte_enables_n;
        acc_ha   <= host_address_inputs;
      end
    end
  end

  // ---------------------------------------------------------
  // host registers and interrupts
  // ---------------------------------------------------------
  wire        reg_write = strobe_end & ~acc_read & type_ok & word_done;
  wire        ctl_write = reg_write & (acc_type == host_port_pkg::ACC_CONTROL);
  wire        adr_write = reg_write & (acc_type == host_port_pkg::ACC_ADDRESS);
  wire        data_push = fifo_push & fifo_in_ready;

  // processor-set host interrupt, set wins over clear
  wire next_cpu_int  = ctl_write ? wr_word[host_port_pkg::CTL_CPU_INT]
                                 : control_reg[host_port_pkg::CTL_CPU_INT];
  wire next_host_int = host_int_set |
                       (control_reg[host_port_pkg::CTL_HOST_INT] &
                        ~(ctl_write & wr_word[host_port_pkg::CTL_HOST_INT]));

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      control_reg <= host_port_pkg::CTL_RESET;
      address_reg <= 32'h0000_0000;
      low_half    <= 16'h0000;
      wr_word_q   <= 32'h0000_0000;
    end else begin
      control_reg[host_port_pkg::CTL_CPU_INT]  <= next_cpu_int;
      control_reg[host_port_pkg::CTL_HOST_INT] <= next_host_int;
      if (strobe_end && !acc_read && cfg_half && !acc_half)
        low_half <= host_data_bus_in[15:0];
      if (strobe_end && !acc_read)
        wr_word_q <= wr_word;
      if (adr_write)
        address_reg <= wr_word;
      else if (data_push && is_inc)
        address_reg <= address_reg + addr_step;
    end
  end

  assign cpu_interrupt        = control_reg[host_port_pkg::CTL_CPU_INT];
  assign host_interrupt_out_n = ~control_reg[host_port_pkg::CTL_HOST_INT];

  // ---------------------------------------------------------
  // read data path
  // ---------------------------------------------------------
  // refused address reads in non-multiplexed mode return the control word
  wire        adr_read = type_ok & (acc_type == host_port_pkg::ACC_ADDRESS);
  wire [31:0] reg_word = adr_read ? address_reg : control_reg;

  // presented word: register reads, memory data, or its upper half
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      read_word <= 32'h0000_0000;
      out_word  <= 32'h0000_0000;
    end else if (state == st_rd_wait && mem_rvalid) begin
      read_word <= mem_rdata;
      out_word  <= cfg_half ? {16'h0000, mem_rdata[15:0]} : mem_rdata;
    end else if (strobe_s2 && acc_read && !is_data) begin
      out_word  <= cfg_half ? {16'h0000, (acc_half ? reg_word[31:16] : reg_word[15:0])}
                            : reg_word;
    end else if (strobe_s2 && acc_read && is_data && cfg_half && acc_half) begin
      out_word  <= {16'h0000, read_word[31:16]};
    end
  end

  wire drive_rd = strobe_raw & host_read & cfg_en;
  assign host_data_bus_out = out_word;
  assign host_data_bus_oe  = {{16{drive_rd & ~upper_lines_gpio}}, {16{drive_rd}}};

  // ---------------------------------------------------------
  // ready toward the host
  // ---------------------------------------------------------
  // wait until done
  wire busy = (state != st_idle) | (strobe_start & (next_state != st_idle));
  assign host_ready_out = ~(busy & ~host_chip_select_n);
endmodule

// File: rtl/host_port_pkg.sv
/*
  shared constants and carrier types for the parallel host port.
  assumes one 20 MHz clock domain and an internal memory with a
  valid/ready request side and a one-beat read response.
*/
package host_port_pkg;
  // -------------------------------------------------------------
  // access types on the two type pins
  // -------------------------------------------------------------
  localparam logic [1:0] ACC_CONTROL  = 2'h0;  // control register
  localparam logic [1:0] ACC_DATA_INC = 2'h1;  // data, autoincrement
  localparam logic [1:0] ACC_ADDRESS  = 2'h2;  // address register
  localparam logic [1:0] ACC_DATA     = 2'h3;  // data, fixed address
  // -------------------------------------------------------------
  // configuration bit positions
  // -------------------------------------------------------------
  localparam int CFG_ENABLE  = 0;  // port enable
  localparam int CFG_PAGE    = 1;  // page mode (multiplexed only)
  localparam int CFG_NONMUX  = 2;  // non-multiplexed mode
  localparam int CFG_FULL    = 3;  // fullword multiplexed
  localparam int CFG_BYTEAD  = 4;  // host address is a byte address
  localparam int CFG_WIDTH   = 5;
  // -------------------------------------------------------------
  // control register bits seen by the host
  // -------------------------------------------------------------
  localparam int CTL_CPU_INT  = 1;  // host sets: interrupt to processor
  localparam int CTL_HOST_INT = 2;  // processor sets, host writes 1 clears
  localparam logic [31:0] CTL_RESET = 32'h0000_0000;
  // -------------------------------------------------------------
  // widths and address steps
  // -------------------------------------------------------------
  localparam int DATA_WIDTH = 32;
  localparam int HALF_WIDTH = 16;
  localparam logic [31:0] STEP_BYTE = 32'h0000_0004;  // one word in bytes
  localparam logic [31:0] STEP_WORD = 32'h0000_0001;  // one word in words
  localparam int FIFO_DEPTH = 32;

  // one internal memory request
  typedef struct packed {
    logic        write;  // 1 write, 0 read
    logic [3:0]  be;     // byte enables, active high
    logic [31:0] addr;   // byte address
    logic [31:0] data;   // write data
  } mem_req_type;
endpackage

// File: tb/host_port_sva.sv
/*
  checker for the host port top, seeing only its ports.
  assumes a single mclk domain with reset_n asynchronous, active low.
*/
`timescale 1ns/1ps
// ---------------------------------------------------------------
// port checker
// ---------------------------------------------------------------
module host_port_sva (
  input wire logic                       mclk,
  input wire logic                       reset_n,
  input wire logic                       host_chip_select_n,
  input wire logic                       host_read,
  input wire logic [31:0]                host_data_bus_oe,
  input wire logic                       host_ready_out,
  input wire logic                       host_interrupt_out_n,
  input wire logic [4:0]                 host_port_config,
  input wire logic [7:0]                 page_addr_top_byte,
  input wire logic [7:0]                 page_addr_upper_mid_byte,
  input wire logic                       upper_lines_gpio,
  input wire logic                       host_int_set,
  input wire logic                       memory_upper_data_pins_input,
  input wire logic                       mem_valid,
  input wire logic                       mem_ready,
  input wire host_port_pkg::mem_req_type mem_req,
  input wire logic                       mem_rvalid
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // page bits replace the host's upper address
  wire page_on = host_port_config[1] | host_port_config[2];

  a_ready_needs_select: assert property (!host_ready_out |-> !host_chip_select_n)
    else $error("ready low without chip select");
  a_nonmux_pins_input: assert property (
    memory_upper_data_pins_input == host_port_config[2])
    else $error("shared pins direction wrong");
  a_gpio_upper_off: assert property (upper_lines_gpio |-> host_data_bus_oe[31:16] == 16'h0)
    else $error("upper lines driven while gpio");
  a_oe_read_only: assert property (|host_data_bus_oe |-> host_read && !host_chip_select_n)
    else $error("data bus driven outside a read");
  a_page_force: assert property (mem_valid && page_on |->
    mem_req.addr[31:16] == {page_addr_top_byte, page_addr_upper_mid_byte})
    else $error("page bits not forced");
  a_rvalid_ready: assert property (mem_rvalid |=> host_ready_out)
    else $error("ready not released after read data");
  a_req_hold: assert property (mem_valid && !mem_ready |=> mem_valid && $stable(mem_req))
    else $error("request changed while stalled");
  a_ready_bound: assert property ($fell(host_ready_out) |-> ##[1:400] host_ready_out)
    else $error("ready held low too long");
  a_host_int_set: assert property (host_int_set |=> !host_interrupt_out_n)
    else $error("host interrupt not raised");
endmodule
bind parallel_host_port_interface host_port_sva chk_u (
  .mclk(mclk), .reset_n(reset_n), .host_chip_select_n(host_chip_select_n),
  .host_read(host_read), .host_data_bus_oe(host_data_bus_oe),
  .host_ready_out(host_ready_out), .host_interrupt_out_n(host_interrupt_out_n),
  .host_port_config(host_port_config), .page_addr_top_byte(page_addr_top_byte),
  .page_addr_upper_mid_byte(page_addr_upper_mid_byte), .upper_lines_gpio(upper_lines_gpio),
  .host_int_set(host_int_set), .memory_upper_data_pins_input(memory_upper_data_pins_input),
  .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req), .mem_rvalid(mem_rvalid));

// File: tb/mem_partner_model.sv
/*
  internal memory model on the far side of the request fifo.
  assumes one read outstanding at a time; stall holds ready low.
*/
`timescale 1ns/1ps
module mem_partner_model (
  // clock, reset and stall control
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       stall,
  // request side
  input  wire logic                       mem_valid,
  output logic                            mem_ready,
  input  wire host_port_pkg::mem_req_type mem_req,
  // response side and probe
  output logic                            mem_rvalid,
  output logic [31:0]                     mem_rdata,
  output logic [31:0]                     last_addr
);
  logic [31:0] store [64];  // word store, index from addr[7:2]
  logic [1:0]  wait_cnt;    // read latency countdown
  logic [5:0]  rd_idx;      // pending read index
  assign mem_ready = !stall;
  // accept requests, answer reads two cycles later
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      wait_cnt   <= 2'h0;
      mem_rvalid <= 1'b0;
      mem_rdata  <= 32'h0;
      last_addr  <= 32'h0;
    end else begin
      mem_rvalid <= 1'b0;
      // data is not valid between answers, so it keeps moving
      mem_rdata  <= ~mem_rdata;
      if (wait_cnt == 2'h1) begin
        mem_rvalid <= 1'b1;
        mem_rdata  <= store[rd_idx];
      end
      if (wait_cnt != 2'h0) wait_cnt <= wait_cnt - 2'h1;
      if (mem_valid && mem_ready) begin
        last_addr <= mem_req.addr;
        rd_idx    <= mem_req.addr[7:2];
        if (!mem_req.write) wait_cnt <= 2'h2;
        for (int b = 0; b < 4; b++) begin
          if (mem_req.write && mem_req.be[b]) store[mem_req.addr[7:2]][8*b+:8] <= mem_req.data[8*b+:8];
        end
      end
    end
  end
endmodule

// File: tb/parallel_host_port_interface_bench.sv
/*
  self-checking bench for the host port, acting as the external host.
  assumes the memory partner model and the bound checker.
*/
`timescale 1ns/1ps
module parallel_host_port_interface_bench;
  logic mclk, reset_n, cs_n, rdn, half, gpio, iset, stall, mem_valid, mem_ready, mem_rvalid;
  logic host_ready_out, host_interrupt_out_n, cpu_interrupt;
  logic [1:0] ds_n, acc;
  logic [3:0] be_n;
  logic [4:0] cfg;
  logic [7:0] top, mid;
  logic [15:0] ha;
  logic [31:0] din, dout, host_data_bus_oe, mem_rdata, last_addr, rv;
  host_port_pkg::mem_req_type mem_req;
  int fail_count = 0;
  int compares = 0;
  parallel_host_port_interface dut_u (.mclk(mclk), .reset_n(reset_n),
    .host_chip_select_n(cs_n), .host_data_strobes_n(ds_n), .host_access_type(acc),
    .host_read(rdn), .host_byte_enables_n(be_n), .halfword_select(half),
    .host_address_inputs(ha), .host_data_bus_in(din), .host_data_bus_out(dout),
    .host_data_bus_oe(host_data_bus_oe), .host_ready_out(host_ready_out),
    .host_interrupt_out_n(host_interrupt_out_n), .host_port_config(cfg),
    .page_addr_top_byte(top), .page_addr_upper_mid_byte(mid), .upper_lines_gpio(gpio),
    .host_int_set(iset), .cpu_interrupt(cpu_interrupt), .memory_upper_data_pins_input(),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  mem_partner_model mem_u (.mclk(mclk), .reset_n(reset_n), .stall(stall),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_req(mem_req),
    .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata), .last_addr(last_addr));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic tick;
    @(posedge mclk);
    #2;
  endtask
  task automatic check32(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic check1(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (host_ready_out !== 1'b1 && n < 500) begin
      tick;
      n++;
    end
    if (n >= 500) begin
      fail_count++;
      $display("BAD ready expected 1 seen %b", host_ready_out);
    end
  endtask
  // one strobe: select plus exactly one strobe low, held until ready
  task automatic xfer(input logic [1:0] t, input logic r, input logic hf, input logic [31:0] wd);
    tick;
    cs_n = 1'b0; ds_n = 2'b10; acc = t; rdn = r; half = hf; din = r ? ~din : wd;
    repeat (4) tick;
    wait_ready;
    tick;
    rv = dout;
    ds_n = 2'b11;
    repeat (3) tick;
    wait_ready;
    tick;
    cs_n = 1'b1;
    din = ~din;
  endtask
  task automatic wr(input logic [1:0] t, input logic [31:0] d);
    xfer(t, 1'b0, 1'b0, d);
  endtask
  task automatic rdc(input logic [1:0] t, input logic [31:0] e);
    xfer(t, 1'b1, 1'b0, 32'h0);
    check32("host read", e, rv);
  endtask
  task automatic summarize;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #(50 * 20000);
    fail_count++;
    summarize;
  end
  initial begin
    cs_n = 1'b1; ds_n = 2'b11; acc = 2'h0; rdn = 1'b0; be_n = 4'h0; half = 1'b0;
    ha = 16'h0; din = 32'h0; cfg = 5'h00; top = 8'hab; mid = 8'hcd;
    gpio = 1'b0; iset = 1'b0; stall = 1'b0; reset_n = 1'b0;
    repeat (6) @(posedge mclk);
    check1("ready in reset", 1'b1, host_ready_out);
    check32("oe in reset", 32'h0, host_data_bus_oe);
    check1("int in reset", 1'b1, host_interrupt_out_n);
    #2 reset_n = 1'b1;
    wr(host_port_pkg::ACC_ADDRESS, 32'h0000_0100);
    wr(host_port_pkg::ACC_DATA, 32'h0000_0005);
    check32("disabled addr", 32'h0, last_addr);
    cfg = 5'h19;
    wr(host_port_pkg::ACC_ADDRESS, 32'h0000_0100);
    for (int i = 0; i < 3; i++) wr(host_port_pkg::ACC_DATA_INC, 32'h1111_0000 + i);
    wr(host_port_pkg::ACC_ADDRESS, 32'h0000_0100);
    for (int i = 0; i < 3; i++) rdc(host_port_pkg::ACC_DATA_INC, 32'h1111_0000 + i);
    check32("inc addr", 32'h0000_0108, last_addr);
    wr(host_port_pkg::ACC_ADDRESS, 32'h0000_0200);
    wr(host_port_pkg::ACC_DATA, 32'ha5a5_0001);
    wr(host_port_pkg::ACC_DATA, 32'ha5a5_0002);
    rdc(host_port_pkg::ACC_DATA, 32'ha5a5_0002);
    check32("fixed addr", 32'h0000_0200, last_addr);
    wr(host_port_pkg::ACC_CONTROL, 32'h0000_0002);
    check1("cpu int", 1'b1, cpu_interrupt);
    wr(host_port_pkg::ACC_CONTROL, 32'h0000_0000);
    check1("cpu int", 1'b0, cpu_interrupt);
    iset = 1'b1;
    tick;
    iset = 1'b0;
    check1("host int", 1'b0, host_interrupt_out_n);
    rdc(host_port_pkg::ACC_CONTROL, 32'h0000_0004);
    wr(host_port_pkg::ACC_CONTROL, 32'h0000_0004);
    check1("host int", 1'b1, host_interrupt_out_n);
    cfg = 5'h1b;
    wr(host_port_pkg::ACC_ADDRESS, 32'h1234_0010);
    wr(host_port_pkg::ACC_DATA, 32'h0000_0077);
    check32("page addr", 32'habcd_0010, last_addr);
    cfg = 5'h11;
    gpio = 1'b1;
    xfer(host_port_pkg::ACC_ADDRESS, 1'b0, 1'b0, 32'h0000_0300);
    xfer(host_port_pkg::ACC_ADDRESS, 1'b0, 1'b1, 32'h0000_0000);
    xfer(host_port_pkg::ACC_DATA, 1'b0, 1'b0, 32'h0000_2468);
    xfer(host_port_pkg::ACC_DATA, 1'b0, 1'b1, 32'h0000_1357);
    xfer(host_port_pkg::ACC_DATA, 1'b1, 1'b0, 32'h0);
    check32("low half", 32'h2468, {16'h0, rv[15:0]});
    xfer(host_port_pkg::ACC_DATA, 1'b1, 1'b1, 32'h0);
    check32("high half", 32'h1357, {16'h0, rv[15:0]});
    gpio = 1'b0;
    cfg = 5'h15;
    ha = 16'h0040;
    wr(host_port_pkg::ACC_DATA, 32'hc3c3_0040);
    check32("nonmux addr", 32'habcd_0040, last_addr);
    wr(host_port_pkg::ACC_DATA_INC, 32'h0000_dead);
    rdc(host_port_pkg::ACC_DATA, 32'hc3c3_0040);
    cfg = 5'h19;
    wr(host_port_pkg::ACC_ADDRESS, 32'h0000_0000);
    stall = 1'b1;
    for (int i = 0; i < 32; i++) wr(host_port_pkg::ACC_DATA_INC, i);
    fork
      wr(host_port_pkg::ACC_DATA_INC, 32'h0000_0020);
      begin
        repeat (40) tick;
        check1("ready when full", 1'b0, host_ready_out);
        stall = 1'b0;
      end
    join
    wr(host_port_pkg::ACC_ADDRESS, 32'h0000_0080);
    rdc(host_port_pkg::ACC_DATA_INC, 32'h0000_0020);
    summarize;
  end
endmodule
